// ===== rtl/rosr_pkg.sv
// constants and carrier types for the relative offset store and recall controller
// assumes a single clk_sys domain and an apb slave with 32-bit data
`default_nettype none
package rosr_pkg;
  localparam int ROSR_ENTRIES = 11;
  localparam int ROSR_DW = 16;
  localparam int ROSR_FW = 32;

  // apb byte addresses
  localparam logic [7:0] ROSR_ADDR_CMD = 8'h00;
  localparam logic [7:0] ROSR_ADDR_FREQ = 8'h04;
  localparam logic [7:0] ROSR_ADDR_CFG = 8'h08;
  localparam logic [7:0] ROSR_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ROSR_ADDR_XOFF = 8'h10;
  localparam logic [7:0] ROSR_ADDR_YOFF = 8'h14;
  localparam logic [7:0] ROSR_ADDR_MAGOFF = 8'h18;
  localparam logic [7:0] ROSR_ADDR_PHASE = 8'h1c;
  localparam logic [7:0] ROSR_ADDR_ROT = 8'h20;

  // command register bit positions (write one to issue)
  localparam int ROSR_CMD_REL_TOGGLE = 0;
  localparam int ROSR_CMD_CAP_XY = 1;
  localparam int ROSR_CMD_CAP_POL = 2;
  localparam int ROSR_CMD_CLR_ALL = 3;
  localparam int ROSR_CMD_CLR_ONE = 4;
  localparam int ROSR_CMD_SCAN_ADV = 5;

  // band test: 100 * |f - fs| <= fs gives a one percent band, edges included
  localparam logic [39:0] ROSR_BAND_DIV = 40'h64;

  localparam logic [ROSR_FW-1:0] ROSR_FREQ_RST = 32'h0000_0000;
  localparam logic [ROSR_DW-1:0] ROSR_CFG_RST = 16'h0000;
  localparam logic [ROSR_DW-1:0] ROSR_VAL_RST = 16'h0000;

  typedef struct packed {
    logic rel_toggle;
    logic cap_xy;
    logic cap_pol;
    logic clr_all;
    logic clr_one;
    logic scan_adv;
    logic cfg_change;
  } rosr_cmd_type;

  typedef struct packed {
    logic [ROSR_DW-1:0] x;
    logic [ROSR_DW-1:0] y;
    logic [ROSR_DW-1:0] mag;
    logic [ROSR_DW-1:0] phase;
  } rosr_meas_type;

  typedef struct packed {
    logic [ROSR_FW-1:0] freq;
    logic xy_v;
    logic pol_v;
    logic [ROSR_DW-1:0] x;
    logic [ROSR_DW-1:0] y;
    logic [ROSR_DW-1:0] mag;
    logic [ROSR_DW-1:0] phase;
    logic [ROSR_DW-1:0] cap_phase;
    logic [ROSR_DW-1:0] cfg;
  } rosr_entry_type;

  typedef struct packed {
    logic first_rel;
    logic second_rel;
    logic x_on;
    logic y_on;
    logic mag_on;
    logic cart_flag;
    logic pol_flag;
    logic rel_mode;
    logic scan_en;
  } rosr_ind_type;

  typedef struct packed {
    logic [3:0] match_idx;
    logic match_hit;
    logic cap_refused;
    rosr_ind_type ind;
  } rosr_status_type;
endpackage
`default_nettype wire

// ===== rtl/rosr_top.sv
// relative offset store and recall controller with apb register access
// assumes commands come from a key decoder on clk_sys and/or apb writes,
// and auto-offset / auto-phase results are presented by the datapath
//
// Design decisions made here: the address map and register access over APB.
`default_nettype none
module rosr_top
  import rosr_pkg::*;
#(
  parameter int ENTRIES = ROSR_ENTRIES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // key decoder commands, one-cycle pulses
  input wire rosr_pkg::rosr_cmd_type pnl_cmd,
  input wire logic [rosr_pkg::ROSR_DW-1:0] pnl_cfg,
  // scan generator
  input wire logic gen_freq_wr,
  input wire logic [rosr_pkg::ROSR_FW-1:0] gen_freq,
  input wire logic scan_at_stop,
  output logic scan_step,
  // datapath auto results
  input wire rosr_pkg::rosr_meas_type auto_res,
  // applied setup
  output rosr_pkg::rosr_meas_type off_out,
  output logic [rosr_pkg::ROSR_DW-1:0] rot_angle,
  output logic [rosr_pkg::ROSR_DW-1:0] cfg_out,
  output rosr_pkg::rosr_ind_type ind
);
  import rosr_pkg::*;
  localparam int IW = $clog2(ENTRIES);
  rosr_entry_type ent_q [ENTRIES];
  logic [ROSR_FW-1:0] freq_q;
  logic [ROSR_DW-1:0] cfg_q;
  rosr_meas_type off_q;
  logic [ROSR_DW-1:0] rot_q;
  logic rel_q, scan_q, applied_q, step_q, refused_q;
  logic xon_q, yon_q, magon_q;
  logic hit_q, pend1_q, pend2_q;
  logic [IW-1:0] idx_q;
  logic hit_d, free_ok;
  logic [IW-1:0] idx_d, free_idx, tgt;
  logic [ENTRIES-1:0] used_vec;
  logic apb_wr, apb_setup, freq_wr, do_recall, tgt_ok;
  rosr_cmd_type bus_cmd, cmd;
  rosr_entry_type cur_ent;
  logic [31:0] rd_d;
  logic addr_ok;
  rosr_status_type status;
  function automatic logic rosr_in_band(input logic [ROSR_FW-1:0] f,
                                        input logic [ROSR_FW-1:0] fs);
    logic [ROSR_FW-1:0] diff;
    logic [39:0] scaled;
    diff = (f >= fs) ? f - fs : fs - f;
    scaled = {8'h00, diff} * ROSR_BAND_DIV;
    return scaled <= {8'h00, fs};
  endfunction
  // apb: zero wait states, read data captured in the setup cycle
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign pready = psel & penable;
  always_comb begin
    bus_cmd = '0;
    if (apb_wr && paddr == ROSR_ADDR_CMD) begin
      bus_cmd.rel_toggle = pwdata[ROSR_CMD_REL_TOGGLE];
      bus_cmd.cap_xy = pwdata[ROSR_CMD_CAP_XY];
      bus_cmd.cap_pol = pwdata[ROSR_CMD_CAP_POL];
      bus_cmd.clr_all = pwdata[ROSR_CMD_CLR_ALL];
      bus_cmd.clr_one = pwdata[ROSR_CMD_CLR_ONE];
      bus_cmd.scan_adv = pwdata[ROSR_CMD_SCAN_ADV];
    end
    bus_cmd.cfg_change = apb_wr && paddr == ROSR_ADDR_CFG;
  end
  assign cmd = pnl_cmd | bus_cmd;
  assign freq_wr = gen_freq_wr | (apb_wr && paddr == ROSR_ADDR_FREQ);
  // descending scan so the lowest matching index is the one kept
  always_comb begin
    hit_d = 1'b0;
    idx_d = '0;
    free_ok = 1'b0;
    free_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      used_vec[i] = ent_q[i].xy_v | ent_q[i].pol_v;
      if (used_vec[i] && rosr_in_band(freq_q, ent_q[i].freq)) begin
        hit_d = 1'b1;
        idx_d = IW'(i);
      end
      if (!used_vec[i]) begin
        free_ok = 1'b1;
        free_idx = IW'(i);
      end
    end
  end
  assign tgt_ok = hit_d | free_ok;
  assign tgt = hit_d ? idx_d : free_idx;
  assign cur_ent = ent_q[idx_q];
  assign do_recall = pend2_q && rel_q && hit_q && (cur_ent.xy_v | cur_ent.pol_v);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hit_q <= 1'b0;
      idx_q <= '0;
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
      idx_q <= idx_d;
      // turning the mode on re-runs the recall path
      pend1_q <= freq_wr | (cmd.rel_toggle & ~rel_q);
      pend2_q <= pend1_q;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      freq_q <= ROSR_FREQ_RST;
    end else if (gen_freq_wr) begin
      freq_q <= gen_freq;
    end else if (freq_wr) begin
      freq_q <= pwdata;
    end
  end
  // entry table
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        ent_q[i] <= '0;
      end
      refused_q <= 1'b0;
    end else if (cmd.clr_all) begin
      for (int i = 0; i < ENTRIES; i++) begin
        ent_q[i].xy_v <= 1'b0;
        ent_q[i].pol_v <= 1'b0;
      end
    end else if (cmd.clr_one) begin
      if (hit_d) begin
        ent_q[idx_d].xy_v <= 1'b0;
        ent_q[idx_d].pol_v <= 1'b0;
      end
    end else if (cmd.cap_xy || cmd.cap_pol) begin
      refused_q <= ~tgt_ok;
      if (tgt_ok) begin
        if (!hit_d) begin
          ent_q[tgt].freq <= freq_q;
          ent_q[tgt].xy_v <= 1'b0;
          ent_q[tgt].pol_v <= 1'b0;
        end
        ent_q[tgt].cfg <= cfg_q;
        ent_q[tgt].cap_phase <= off_q.phase;
        if (cmd.cap_xy) begin
          ent_q[tgt].x <= auto_res.x;
          ent_q[tgt].y <= auto_res.y;
          ent_q[tgt].xy_v <= 1'b1;
          if (hit_d && ent_q[tgt].cfg != cfg_q) begin
            ent_q[tgt].pol_v <= 1'b0;
          end
        end else begin
          ent_q[tgt].mag <= auto_res.mag;
          ent_q[tgt].phase <= auto_res.phase;
          ent_q[tgt].pol_v <= 1'b1;
          if (hit_d && ent_q[tgt].cfg != cfg_q) begin
            ent_q[tgt].xy_v <= 1'b0;
          end
        end
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rel_q <= 1'b0;
    end else if (cmd.rel_toggle) begin
      rel_q <= ~rel_q;
    end
  end
  // configuration: a recall load is not a user change
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= ROSR_CFG_RST;
    end else if (do_recall) begin
      cfg_q <= cur_ent.cfg;
    end else if (pnl_cmd.cfg_change) begin
      cfg_q <= pnl_cfg;
    end else if (bus_cmd.cfg_change) begin
      cfg_q <= pwdata[ROSR_DW-1:0];
    end
  end
  // offsets and reference phase; capture wins over a recall in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      off_q <= '0;
      rot_q <= ROSR_VAL_RST;
      xon_q <= 1'b0;
      yon_q <= 1'b0;
      magon_q <= 1'b0;
    end else if (cmd.cap_xy && !cmd.clr_all && !cmd.clr_one) begin
      off_q.x <= auto_res.x;
      off_q.y <= auto_res.y;
      rot_q <= ROSR_VAL_RST;
      xon_q <= 1'b1;
      yon_q <= 1'b1;
    end else if (cmd.cap_pol && !cmd.clr_all && !cmd.clr_one) begin
      off_q.mag <= auto_res.mag;
      off_q.phase <= auto_res.phase;
      magon_q <= 1'b1;
    end else if (do_recall) begin
      if (cur_ent.xy_v) begin
        off_q.x <= cur_ent.x;
        off_q.y <= cur_ent.y;
        // the datapath rotates x/y by this angle: phase now minus phase at capture
        rot_q <= (cur_ent.pol_v ? cur_ent.phase : off_q.phase) - cur_ent.cap_phase;
        xon_q <= 1'b1;
        yon_q <= 1'b1;
      end
      if (cur_ent.pol_v) begin
        off_q.mag <= cur_ent.mag;
        off_q.phase <= cur_ent.phase;
        magon_q <= 1'b1;
      end
    end
  end
  // applied indicator: recall sets, user change or failed match clears; set wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      applied_q <= 1'b0;
    end else if (do_recall) begin
      applied_q <= 1'b1;
    end else if (cmd.cfg_change || pend2_q) begin
      applied_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scan_q <= 1'b0;
      step_q <= 1'b0;
    end else begin
      step_q <= 1'b0;
      if (cmd.scan_adv) begin
        if (scan_q && scan_at_stop) begin
          scan_q <= 1'b0;
        end else begin
          scan_q <= 1'b1;
          step_q <= 1'b1;
        end
      end
    end
  end
  always_comb begin
    ind.first_rel = applied_q;
    ind.second_rel = applied_q;
    ind.x_on = xon_q;
    ind.y_on = yon_q;
    ind.mag_on = magon_q;
    ind.cart_flag = hit_q & cur_ent.xy_v;
    ind.pol_flag = hit_q & cur_ent.pol_v;
    ind.rel_mode = rel_q;
    ind.scan_en = scan_q;
  end
  assign status = '{match_idx: 4'(idx_q), match_hit: hit_q, cap_refused: refused_q, ind: ind};
  assign off_out = off_q;
  assign rot_angle = rot_q;
  assign cfg_out = cfg_q;
  assign scan_step = step_q;
  always_comb begin
    rd_d = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr == ROSR_ADDR_CMD) begin
      rd_d = 32'h0000_0000;
    end else if (paddr == ROSR_ADDR_FREQ) begin
      rd_d = freq_q;
    end else if (paddr == ROSR_ADDR_CFG) begin
      rd_d = {16'h0000, cfg_q};
    end else if (paddr == ROSR_ADDR_STATUS) begin
      rd_d = 32'({status});
    end else if (paddr == ROSR_ADDR_XOFF) begin
      rd_d = {16'h0000, off_q.x};
    end else if (paddr == ROSR_ADDR_YOFF) begin
      rd_d = {16'h0000, off_q.y};
    end else if (paddr == ROSR_ADDR_MAGOFF) begin
      rd_d = {16'h0000, off_q.mag};
    end else if (paddr == ROSR_ADDR_PHASE) begin
      rd_d = {16'h0000, off_q.phase};
    end else if (paddr == ROSR_ADDR_ROT) begin
      rd_d = {16'h0000, rot_q};
    end else begin
      addr_ok = 1'b0;
    end
  end
  logic err_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
      err_q <= ~addr_ok;
    end
  end
  assign pslverr = pready & err_q;
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_rel_toggle: assert property (cmd.rel_toggle |=> rel_q != $past(rel_q))
    else $error("relative mode did not invert");
  a_cfg_clears_rel: assert property (cmd.cfg_change && !do_recall |=> !applied_q)
    else $error("configuration change left applied set");
  a_cfg_keeps_mode: assert property (cmd.cfg_change && !cmd.rel_toggle |=> $stable(rel_q))
    else $error("configuration change altered relative mode");
  a_recall_applied: assert property (do_recall |=> applied_q && ind.first_rel && ind.second_rel)
    else $error("recall did not light both channels");
  a_recall_phase: assert property (do_recall && cur_ent.pol_v && !cmd.cap_xy && !cmd.cap_pol
                                   |=> off_q.phase == $past(cur_ent.phase))
    else $error("recalled angle not loaded as phase");
  a_nomatch_off: assert property (pend2_q && !do_recall |=> !applied_q)
    else $error("applied set without a match");
  a_freq_recall: assert property (freq_wr && !gen_freq_wr && rel_q && !cmd.rel_toggle
                                  |-> ##2 pend2_q)
    else $error("frequency update did not reach recall stage");
  a_clear_all: assert property (cmd.clr_all |=> used_vec == '0)
    else $error("entries survived clear-all");
  a_full_refuse: assert property (cmd.cap_xy && !cmd.clr_all && !cmd.clr_one && !tgt_ok
                                  |=> $stable(used_vec) && refused_q)
    else $error("capture accepted with a full table");
  a_scan_stop: assert property (cmd.scan_adv && scan_q && scan_at_stop
                                |=> !scan_q && !scan_step)
    else $error("scan advanced past stop");
  a_mode_off_hold: assert property (pend2_q && !rel_q && !cmd.cap_xy && !cmd.cap_pol
                                    |=> $stable(off_q))
    else $error("offsets changed with relative mode off");
  c_recall: cover property (do_recall ##1 applied_q);
  c_refuse: cover property (cmd.cap_xy && !tgt_ok);
  c_scan_stop: cover property (cmd.scan_adv && scan_q && scan_at_stop);
  c_clear_one: cover property (cmd.clr_one && hit_d);
endmodule
`default_nettype wire

// ===== verification/rosr_keypad_model.sv
// key decoder model: turns held keys into one-cycle command pulses
// assumes the bench holds a key for one or more clk_sys cycles
`default_nettype none
module rosr_keypad_model
  import rosr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // keys from the bench
  input wire rosr_pkg::rosr_cmd_type key,
  input wire logic [rosr_pkg::ROSR_DW-1:0] key_cfg,
  // to the controller
  output rosr_pkg::rosr_cmd_type pnl_cmd,
  output logic [rosr_pkg::ROSR_DW-1:0] pnl_cfg
);
  timeunit 1ns;
  timeprecision 100ps;
  rosr_cmd_type key_q;

  // edge detect so a long press is one command, like a real decoder
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      key_q <= '0;
      pnl_cmd <= '0;
      pnl_cfg <= '0;
    end else begin
      key_q <= key;
      pnl_cmd <= key & ~key_q;
      // cfg is only meaningful with the strobe; otherwise keep it moving
      pnl_cfg <= (key.cfg_change && !key_q.cfg_change) ? key_cfg : ~pnl_cfg;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the relative store/recall controller
// assumes stimulus on clk_sys edges and a recall three edges after an update
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rosr_pkg::*;
  logic clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic pready, pslverr, ev, gen_freq_wr = 0, scan_at_stop = 0, scan_step;
  logic [ROSR_FW-1:0] gen_freq = '0;
  logic [ROSR_DW-1:0] key_cfg = '0, pnl_cfg, rot_angle, cfg_out;
  rosr_cmd_type key = '0, pnl_cmd;
  rosr_meas_type auto_res = 64'h0101_0202_0303_0404, off_out;
  rosr_ind_type ind;
  int fails = 0, cmp_count = 0, cycles = 0, steps = 0;

  rosr_keypad_model kp (.clk_sys(clk_sys), .arst_n(arst_n), .key(key), .key_cfg(key_cfg),
    .pnl_cmd(pnl_cmd), .pnl_cfg(pnl_cfg));
  rosr_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pnl_cmd(pnl_cmd), .pnl_cfg(pnl_cfg), .gen_freq_wr(gen_freq_wr),
    .gen_freq(gen_freq), .scan_at_stop(scan_at_stop), .scan_step(scan_step),
    .auto_res(auto_res), .off_out(off_out), .rot_angle(rot_angle), .cfg_out(cfg_out),
    .ind(ind));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (scan_step === 1'b1) steps++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one zero-or-more-wait apb transfer, request held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
    cyc(3);
  endtask

  task automatic setf(input logic [31:0] f);
    @(posedge clk_sys);
    gen_freq <= f;
    gen_freq_wr <= 1;
    @(posedge clk_sys);
    gen_freq_wr <= 0;
    cyc(4);
  endtask

  task automatic press(input logic [6:0] k);
    @(posedge clk_sys);
    key <= rosr_cmd_type'(k);
    @(posedge clk_sys);
    key <= '0;
    cyc(5);
  endtask

  task automatic chind(input logic [8:0] e);
    chk("ind", {23'h0, ind}, {23'h0, e});
  endtask

  initial begin
    cyc(16);
    arst_n <= 1;
    cyc(2);
    apb(0, ROSR_ADDR_STATUS, '0);
    chk("status", rv, 32'h0);
    apb(0, 8'h40, '0);
    chk("miss_err", {31'h0, ev}, 32'h1);
    apb(1, ROSR_ADDR_FREQ, 32'd90000);
    apb(1, ROSR_ADDR_CFG, 32'h0011);
    press(7'h10);
    chind(9'h014);
    chk("mag", {16'h0, off_out.mag}, 32'h0303);
    apb(1, ROSR_ADDR_CMD, 32'h2);
    chind(9'h07c);
    chk("xoff", {16'h0, off_out.x}, 32'h0101);
    auto_res <= 64'h0a0a_0b0b_0c0c_0d0d;
    setf(32'd1000);
    chind(9'h070);
    press(7'h40);
    chind(9'h072);
    @(posedge clk_sys);
    key_cfg <= 16'h0022;
    press(7'h01);
    setf(32'd89100);
    chind(9'h1fe);
    chk("cfg_recall", {16'h0, cfg_out}, 32'h0011);
    chk("mag_recall", {16'h0, off_out.mag}, 32'h0303);
    chk("ph_recall", {16'h0, off_out.phase}, 32'h0404);
    chk("x_recall", {16'h0, off_out.x}, 32'h0101);
    chk("rot_recall", {16'h0, rot_angle}, 32'h0);
    setf(32'd89099);
    chind(9'h072);
    chk("cfg_keep", {16'h0, cfg_out}, 32'h0011);
    setf(32'd90900);
    chind(9'h1fe);
    apb(1, ROSR_ADDR_CFG, 32'h0033);
    chind(9'h07e);
    press(7'h40);
    press(7'h40);
    chind(9'h1fe);
    chk("cfg_again", {16'h0, cfg_out}, 32'h0011);
    press(7'h40);
    apb(1, ROSR_ADDR_CFG, 32'h0044);
    setf(32'd1000);
    setf(32'd90000);
    chind(9'h07c);
    chk("cfg_off", {16'h0, cfg_out}, 32'h0044);
    setf(32'd1000);
    press(7'h04);
    setf(32'd90000);
    chind(9'h07c);
    press(7'h04);
    chind(9'h070);
    press(7'h10);
    chind(9'h074);
    apb(1, ROSR_ADDR_CFG, 32'h0055);
    press(7'h20);
    chind(9'h078);
    press(7'h08);
    for (int i = 0; i < 11; i++) begin
      setf(32'd20000 + 32'(i) * 32'd10000);
      press(7'h20);
      apb(0, ROSR_ADDR_STATUS, '0);
      chk("cap_ok", {31'h0, rv[9]}, 32'h0);
      chind(9'h078);
    end
    setf(32'd500000);
    press(7'h20);
    apb(0, ROSR_ADDR_STATUS, '0);
    chk("refused", {31'h0, rv[9]}, 32'h1);
    chind(9'h070);
    setf(32'd120000);
    apb(0, ROSR_ADDR_STATUS, '0);
    chk("idx", {28'h0, rv[14:11]}, 32'ha);
    chind(9'h078);
    press(7'h08);
    chind(9'h070);
    setf(32'd20000);
    chind(9'h070);
    press(7'h02);
    chind(9'h071);
    scan_at_stop <= 1;
    press(7'h02);
    chind(9'h070);
    chk("steps", steps, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
